// ### logic/power_mode_pkg.sv
// constants and types for the charger power mode controller
// How it works
// RL1: four modes: ship, low power, active battery, and charge/adapter.
// RL2: charging, loops, charge-enable pin, current limit only in adapter mode.
// RL3: ship mode: only input undervoltage and pushbutton sensing; all else off.
// RL4: ship latched until input above undervoltage or pushbutton press-release.
// RL5: ship entry ignores the charge-enable pin.
// RL6: battery insertion without input goes to ship mode.
// RL7: ship request with input present waits for input removal.
// RL8: ship request with pushbutton held waits for pushbutton release.
// RL9: pushbutton ship exit needs battery above highest undervoltage level.
// RL10: host may clear ship request; watchdog does not clear it.
// RL11: low power needs pin low, no input, button high, bus idle.
// RL12: low power: internal rail from battery, serial off, clocks stopped.
// RL13: regulator keeps its pre-entry enable state during low power.
// RL14: low power exits on pin high or input above undervoltage.
// RL15: input above overvoltage with pin low runs active battery mode.
// RL16: pin low and pushbutton held runs active battery with clocks.
// RL17: pushbutton released with pin low returns straight to low power.
// RL18: after hardware reset with pin low, pushbutton held till power-up.
// RL19: battery switch off below undervoltage, back on 150 mV above.
// RL20: adapter mode feeds system rail from input, charges to termination.
// RL21: input insertion: internal rail, system rail gated, charging above loop.
// RL22: battery insertion samples pushbutton: ship if high, wake timer if low.
// RL23: comparator and pin inputs are synchronised and filtered.
package power_mode_pkg;

   localparam logic [11:0] CTRL_ADDR = 12'h000;
   localparam logic [11:0] STATUS_ADDR = 12'h004;

   localparam int CLK_PERIOD_NS = 100;
   localparam int FILT_TIME_NS = 500;
   localparam int FILT_CYCLES =
      (FILT_TIME_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
   localparam int FILT_W = 4;
   localparam int SETTLE_CYCLES = FILT_CYCLES + 4;
   localparam int WAKE_PRESS_TIME_MS = 500;
   localparam int WAKE_PRESS_CYCLES =
      WAKE_PRESS_TIME_MS * (1000000 / CLK_PERIOD_NS);
   localparam int WAKE_CNT_W = 24;
   localparam int BAT_UV_HYST_MV = 150;

   typedef enum logic [2:0] {
      MODE_POWER_CHECK,
      MODE_SHIP,
      MODE_WAKE,
      MODE_ACTIVE,
      MODE_LOW_POWER,
      MODE_ADAPTER
   } mode_t;

   typedef struct packed {
      logic path_power_loop_enable_bit;
      logic input_voltage_loop_enable_bit;
      logic charge_enable_bit;
      logic output_regulator_enable_bit;
      logic ship_request_bit;
   } ctrl_t;

   localparam ctrl_t CTRL_RESET = 5'h00;

   // comparator results and pins, all asynchronous to pclk
   typedef struct packed {
      logic in_above_uv;
      logic in_above_ov;
      logic in_above_sleep_margin;
      logic in_above_voltage_loop;
      logic bat_above_uv;
      logic bat_above_uv_hyst;
      logic bat_above_uv_max;
      logic charge_terminated;
      logic pushbutton_n;
      logic low_power_pin_n;
      logic charge_enable_pin_n;
   } sense_t;

   localparam sense_t SENSE_RESET = 11'h007;
   localparam int SENSE_W = $bits(sense_t);

   typedef struct packed {
      logic internal_rail;
      logic system_rail_from_input;
      logic system_rail_from_battery;
      logic battery_switch;
      logic regulator;
      logic serial_port;
      logic irq_output;
      logic low_power_pin_sense;
      logic clocks_run;
      logic charging;
      logic input_voltage_loop;
      logic path_power_loop;
      logic input_current_limit;
      logic battery_overcurrent_sense;
      logic input_overvoltage_sense;
      logic battery_undervoltage_sense;
   } power_out_t;

   localparam power_out_t POWER_OUT_RESET = 16'h8000;

endpackage

// ### logic/charger_power_mode_controller.sv
// power mode state machine with apb control and status registers
//
// The address map and register access over APB were chosen for this implementation.
`timescale 1ns/1ps
`default_nettype none

module charger_power_mode_controller #(
   parameter int unsigned WAKE_CYCLES = power_mode_pkg::WAKE_PRESS_CYCLES
) (
   input wire logic pclk,
   input wire logic presetn,
   input wire logic psel,
   input wire logic penable,
   input wire logic pwrite,
   input wire logic [11:0] paddr,
   input wire logic [31:0] pwdata,
   input wire logic [3:0] pstrb,
   output logic [31:0] prdata,
   output logic pready,
   output logic pslverr,
   input wire power_mode_pkg::sense_t sense,
   input wire logic serial_busy,
   input wire logic irq_pending,
   output power_mode_pkg::power_out_t power
);

   typedef struct packed {
      power_mode_pkg::sense_t sync1;
      power_mode_pkg::sense_t sync2;
      power_mode_pkg::sense_t filt;
      logic [power_mode_pkg::SENSE_W-1:0][power_mode_pkg::FILT_W-1:0] fcnt;
      power_mode_pkg::mode_t mode;
      logic from_ship;
      logic [power_mode_pkg::WAKE_CNT_W-1:0] cnt;
      logic bat_ok;
      logic reg_hold;
      power_mode_pkg::ctrl_t ctrl;
      logic pready;
      logic [31:0] prdata;
      logic pslverr;
      power_mode_pkg::power_out_t out;
   } state_t;

   localparam logic [power_mode_pkg::FILT_W-1:0] FILT_LAST =
      power_mode_pkg::FILT_W'(power_mode_pkg::FILT_CYCLES - 1);
   localparam logic [power_mode_pkg::WAKE_CNT_W-1:0] SETTLE_LAST =
      power_mode_pkg::WAKE_CNT_W'(power_mode_pkg::SETTLE_CYCLES - 1);
   localparam logic [power_mode_pkg::WAKE_CNT_W-1:0] WAKE_LAST =
      power_mode_pkg::WAKE_CNT_W'(WAKE_CYCLES - 1);
   localparam logic [power_mode_pkg::WAKE_CNT_W-1:0] CNT_ZERO =
      power_mode_pkg::WAKE_CNT_W'(0);
   localparam logic [power_mode_pkg::WAKE_CNT_W-1:0] CNT_ONE =
      power_mode_pkg::WAKE_CNT_W'(1);
   localparam logic [power_mode_pkg::FILT_W-1:0] FCNT_ONE =
      power_mode_pkg::FILT_W'(1);

   state_t q;
   state_t next_q;

   // modes in which the host link and the regulator enable are live
   function automatic logic host_mode(input power_mode_pkg::mode_t m);
      host_mode = (m == power_mode_pkg::MODE_ACTIVE) ||
         (m == power_mode_pkg::MODE_ADAPTER);
   endfunction

   // battery-only modes with the switch under the undervoltage latch
   function automatic logic battery_mode(input power_mode_pkg::mode_t m);
      battery_mode = (m == power_mode_pkg::MODE_ACTIVE) ||
         (m == power_mode_pkg::MODE_LOW_POWER);
   endfunction

   always_comb begin
      logic [power_mode_pkg::SENSE_W-1:0] raw;
      logic [power_mode_pkg::SENSE_W-1:0] flt;
      power_mode_pkg::sense_t f;
      power_mode_pkg::mode_t m;
      logic vin;
      logic adapter_go;
      logic ship_go;
      logic lp_go;
      logic access;
      logic ship_clear;
      raw = '0;
      flt = '0;
      f = power_mode_pkg::SENSE_RESET;
      m = power_mode_pkg::MODE_POWER_CHECK;
      vin = 1'b0;
      adapter_go = 1'b0;
      ship_go = 1'b0;
      lp_go = 1'b0;
      access = 1'b0;
      ship_clear = 1'b0;
      next_q = q;

      // two-stage synchroniser, then a stability filter per input
      next_q.sync1 = sense; // [RL23]
      next_q.sync2 = q.sync1; // [RL23]
      raw = q.sync2;
      flt = q.filt;
      for (int i = 0; i < power_mode_pkg::SENSE_W; i++) begin
         if (raw[i] != flt[i]) begin
            if (q.fcnt[i] == FILT_LAST) begin
               flt[i] = raw[i]; // [RL23]
               next_q.fcnt[i] = '0;
            end else begin
               next_q.fcnt[i] = q.fcnt[i] + FCNT_ONE;
            end
         end else begin
            next_q.fcnt[i] = '0;
         end
      end
      next_q.filt = flt;

      // mode decisions use the filtered view of last cycle
      f = q.filt;
      vin = f.in_above_uv;
      // faulty adapter with pin low stays on battery
      adapter_go = vin && !(f.in_above_ov && !f.low_power_pin_n); // [RL15]
      // charge-enable pin plays no part in ship entry
      ship_go = q.ctrl.ship_request_bit && !vin && f.pushbutton_n; // [RL5]
      // serial and interrupt traffic must drain first
      lp_go = !f.low_power_pin_n && !vin && f.pushbutton_n &&
              !serial_busy && !irq_pending; // [RL11]

      case (q.mode)
         power_mode_pkg::MODE_POWER_CHECK: begin
            // rail up briefly; sample the button once inputs settle
            next_q.cnt = q.cnt + CNT_ONE;
            if (q.cnt == SETTLE_LAST) begin
               next_q.cnt = CNT_ZERO;
               if (adapter_go) begin
                  next_q.mode = power_mode_pkg::MODE_ADAPTER; // [RL21]
               end else if (!f.pushbutton_n) begin
                  next_q.mode = power_mode_pkg::MODE_WAKE; // [RL22]
                  next_q.from_ship = 1'b0;
               end else begin
                  next_q.mode = power_mode_pkg::MODE_SHIP; // [RL6] [RL22]
               end
            end
         end
         power_mode_pkg::MODE_SHIP: begin
            if (vin) begin
               next_q.mode = power_mode_pkg::MODE_ADAPTER; // [RL4]
            end else if (!f.pushbutton_n && f.bat_above_uv_max) begin
               next_q.mode = power_mode_pkg::MODE_WAKE; // [RL9]
               next_q.from_ship = 1'b1;
               next_q.cnt = CNT_ZERO;
            end
         end
         power_mode_pkg::MODE_WAKE: begin
            if (adapter_go) begin
               next_q.mode = power_mode_pkg::MODE_ADAPTER;
            end else if (f.pushbutton_n) begin
               // ship exit needs a full press and then a release
               if (q.from_ship && q.cnt == WAKE_LAST) begin
                  next_q.mode = power_mode_pkg::MODE_ACTIVE; // [RL4]
               end else begin
                  next_q.mode = power_mode_pkg::MODE_SHIP; // [RL4]
               end
               next_q.cnt = CNT_ZERO;
            end else if (q.cnt != WAKE_LAST) begin
               next_q.cnt = q.cnt + CNT_ONE;
            end else if (!q.from_ship) begin
               // insertion wake powers up while still held
               next_q.mode = power_mode_pkg::MODE_ACTIVE; // [RL22]
               next_q.cnt = CNT_ZERO;
            end
         end
         power_mode_pkg::MODE_ACTIVE: begin
            if (adapter_go) begin
               next_q.mode = power_mode_pkg::MODE_ADAPTER; // [RL21]
            end else if (ship_go) begin
               next_q.mode = power_mode_pkg::MODE_SHIP; // [RL8]
               ship_clear = 1'b1;
            end else if (lp_go && !f.in_above_ov) begin
               // button held or overvoltage keeps clocks running
               next_q.mode = power_mode_pkg::MODE_LOW_POWER; // [RL16]
               next_q.reg_hold =
                  q.ctrl.output_regulator_enable_bit; // [RL13]
            end
         end
         power_mode_pkg::MODE_LOW_POWER: begin
            if (adapter_go) begin
               next_q.mode = power_mode_pkg::MODE_ADAPTER; // [RL14]
            end else if (f.low_power_pin_n || f.in_above_ov ||
                         !f.pushbutton_n) begin
               next_q.mode = power_mode_pkg::MODE_ACTIVE; // [RL14] [RL16]
            end
         end
         power_mode_pkg::MODE_ADAPTER: begin
            if (!adapter_go) begin
               if (ship_go) begin
                  // deferred ship entry once input is gone
                  next_q.mode = power_mode_pkg::MODE_SHIP; // [RL7]
                  ship_clear = 1'b1;
               end else begin
                  next_q.mode = power_mode_pkg::MODE_ACTIVE;
               end
            end
         end
         default: begin
            next_q.mode = power_mode_pkg::MODE_POWER_CHECK;
         end
      endcase

      // undervoltage latch with 150 mV hysteresis band on battery only
      if (q.mode != power_mode_pkg::MODE_ADAPTER) begin
         if (!f.bat_above_uv) begin
            next_q.bat_ok = 1'b0; // [RL19]
         end else if (f.bat_above_uv_hyst) begin
            next_q.bat_ok = 1'b1; // [RL19]
         end
      end

      // apb: pready comes one cycle into the access phase
      access = psel && penable && q.pready;
      next_q.pready = psel && penable && !q.pready;
      if (psel && penable && !q.pready) begin
         next_q.pslverr = 1'b0;
         if (paddr == power_mode_pkg::CTRL_ADDR) begin
            next_q.prdata = 32'(q.ctrl);
         end else if (paddr == power_mode_pkg::STATUS_ADDR) begin
            next_q.prdata = 32'({q.mode, q.bat_ok, q.filt, q.out});
         end else begin
            next_q.prdata = 32'h00000000;
            next_q.pslverr = 1'b1;
         end
      end

      // hardware clears on ship entry; a write in the same cycle wins
      if (ship_clear) begin
         next_q.ctrl.ship_request_bit = 1'b0;
      end
      if (access && pwrite && pstrb[0] &&
          paddr == power_mode_pkg::CTRL_ADDR) begin
         // host may clear the request; no watchdog path touches it
         next_q.ctrl = power_mode_pkg::ctrl_t'(pwdata[4:0]); // [RL10]
      end

      // outputs follow the next mode so they stand with it
      m = next_q.mode;
      next_q.out = '0;
      next_q.out.internal_rail = (m != power_mode_pkg::MODE_SHIP); // [RL3]
      next_q.out.battery_switch = (m == power_mode_pkg::MODE_ADAPTER) ||
         (battery_mode(m) && next_q.bat_ok); // [RL19] [RL3]
      next_q.out.system_rail_from_input =
         (m == power_mode_pkg::MODE_ADAPTER) &&
         f.in_above_sleep_margin && !f.in_above_ov; // [RL21] [RL20]
      next_q.out.system_rail_from_battery =
         next_q.out.battery_switch &&
         !next_q.out.system_rail_from_input;
      if (m == power_mode_pkg::MODE_LOW_POWER) begin
         next_q.out.regulator = next_q.reg_hold; // [RL13]
      end else if (host_mode(m)) begin
         next_q.out.regulator =
            next_q.ctrl.output_regulator_enable_bit;
      end
      // serial port and interrupt pin off in ship and low power
      next_q.out.serial_port = host_mode(m); // [RL3] [RL12]
      next_q.out.irq_output = next_q.out.serial_port; // [RL3]
      next_q.out.low_power_pin_sense = battery_mode(m); // [RL3]
      next_q.out.clocks_run = (m != power_mode_pkg::MODE_SHIP) &&
         (m != power_mode_pkg::MODE_LOW_POWER); // [RL12] [RL17]
      if (m == power_mode_pkg::MODE_ADAPTER) begin
         next_q.out.charging = next_q.ctrl.charge_enable_bit &&
            !f.charge_enable_pin_n && f.in_above_voltage_loop &&
            !f.charge_terminated &&
            next_q.out.system_rail_from_input; // [RL2] [RL20]
         next_q.out.input_voltage_loop =
            next_q.ctrl.input_voltage_loop_enable_bit; // [RL2]
         next_q.out.path_power_loop =
            next_q.ctrl.path_power_loop_enable_bit; // [RL2]
         next_q.out.input_current_limit = 1'b1; // [RL2]
      end
      next_q.out.battery_overcurrent_sense = host_mode(m);
      next_q.out.input_overvoltage_sense =
         (m != power_mode_pkg::MODE_SHIP); // [RL3]
      next_q.out.battery_undervoltage_sense =
         (m != power_mode_pkg::MODE_SHIP); // [RL3]
      // [RL1] the six encoded states map onto the four primary modes
   end

   always_ff @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         q.sync1 <= power_mode_pkg::SENSE_RESET;
         q.sync2 <= power_mode_pkg::SENSE_RESET;
         q.filt <= power_mode_pkg::SENSE_RESET;
         q.fcnt <= '0;
         q.mode <= power_mode_pkg::MODE_POWER_CHECK;
         q.from_ship <= 1'b0;
         q.cnt <= '0;
         q.bat_ok <= 1'b1;
         q.reg_hold <= 1'b0;
         q.ctrl <= power_mode_pkg::CTRL_RESET;
         q.pready <= 1'b0;
         q.prdata <= 32'h00000000;
         q.pslverr <= 1'b0;
         q.out <= power_mode_pkg::POWER_OUT_RESET;
      end else begin
         q <= next_q;
      end
   end

   assign prdata = q.prdata;
   assign pready = q.pready;
   assign pslverr = q.pslverr;
   assign power = q.out;

endmodule

`default_nettype wire

// ### dv/power_mode_chk.sv
// port assertions for the charger power mode controller
`timescale 1ns/1ps
`default_nettype none
module power_mode_chk #(
   parameter int unsigned WAKE_CYCLES = 20
) (
   input wire logic pclk,
   input wire logic presetn,
   input wire logic psel,
   input wire logic penable,
   input wire logic pwrite,
   input wire logic [11:0] paddr,
   input wire logic [31:0] pwdata,
   input wire logic [3:0] pstrb,
   input wire logic [31:0] prdata,
   input wire logic pready,
   input wire logic pslverr,
   input wire power_mode_pkg::sense_t sense,
   input wire logic serial_busy,
   input wire logic irq_pending,
   input wire power_mode_pkg::power_out_t power
);
   default clocking cb @(posedge pclk); endclocking
   default disable iff (!presetn);

   a_insert_sample: assert property (
      $rose(presetn) |-> (power.internal_rail && !power.battery_switch &&
      !power.system_rail_from_battery && !power.regulator) [*8])
      else $error("rails came up before the button was sampled");
   a_serial_irq_pair: assert property (
      power.serial_port == power.irq_output)
      else $error("serial port and interrupt gating differ");
   a_ship_all_off: assert property (
      !power.internal_rail |-> !(power.serial_port || power.regulator ||
      power.battery_switch || power.low_power_pin_sense ||
      power.input_overvoltage_sense || power.battery_overcurrent_sense))
      else $error("a circuit runs with the internal rail off");
   a_lp_clocks_off: assert property (
      !power.clocks_run |-> !power.serial_port && !power.charging &&
      !power.battery_overcurrent_sense)
      else $error("clocked circuit active with clocks stopped");
   a_charge_adapter: assert property (
      power.charging |-> power.input_current_limit &&
      power.system_rail_from_input)
      else $error("charging outside adapter mode");
   a_loops_adapter: assert property (
      power.input_voltage_loop || power.path_power_loop
      |-> power.input_current_limit)
      else $error("regulation loop outside adapter mode");
   a_lp_pin_sense: assert property (
      power.low_power_pin_sense |->
      power.internal_rail && !power.input_current_limit)
      else $error("low power pin sensed in wrong mode");
   a_lp_regulator_hold: assert property (
      power.internal_rail && $fell(power.clocks_run) &&
      !$past(power.input_current_limit)
      |-> power.regulator == $past(power.regulator))
      else $error("regulator changed on low power entry");
endmodule
`default_nettype wire

// ### dv/far_side_model.sv
// adapter, battery and host pins as seen by the controller
`timescale 1ns/1ps
`default_nettype none
module far_side_model (
   input wire logic pclk,
   input wire power_mode_pkg::sense_t want,
   output var power_mode_pkg::sense_t sense,
   output logic serial_busy,
   output logic irq_pending
);
   logic [3:0] left = 4'h0;
   initial sense = power_mode_pkg::SENSE_RESET;
   // pins follow the commanded levels one edge later
   always @(posedge pclk) begin
      sense <= want;
      // traffic outlives the input filter, so the wait is visible
      if (sense.low_power_pin_n && !want.low_power_pin_n) begin
         left <= 4'hF;
      end else if (left != 4'h0) begin
         left <= left - 4'h1;
      end
   end
   assign irq_pending = (left != 4'h0);
   assign serial_busy = left[3];
endmodule
`default_nettype wire

// ### dv/charger_power_mode_controller_tb.sv
// apb driven mode sequence test of the power mode controller
`timescale 1ns/1ps
`default_nettype none
module charger_power_mode_controller_tb;
   localparam int unsigned WAKE = 20;
   logic pclk, presetn, psel, penable, pwrite, pready, pslverr, rerr;
   logic [11:0] paddr;
   logic [31:0] pwdata, prdata, rd;
   logic [3:0] pstrb;
   logic serial_busy, irq_pending;
   power_mode_pkg::sense_t want, sense;
   power_mode_pkg::power_out_t power;
   int err_total, comparisons;

   charger_power_mode_controller #(.WAKE_CYCLES(WAKE)) DUT (.pclk(pclk),
      .presetn(presetn), .psel(psel), .penable(penable), .pwrite(pwrite),
      .paddr(paddr), .pwdata(pwdata), .pstrb(pstrb), .prdata(prdata),
      .pready(pready), .pslverr(pslverr), .sense(sense),
      .serial_busy(serial_busy), .irq_pending(irq_pending), .power(power));
   far_side_model partner (.pclk(pclk), .want(want), .sense(sense),
      .serial_busy(serial_busy), .irq_pending(irq_pending));

   initial begin
      pclk = 1'b0;
      forever #50 pclk = ~pclk;
   end

   task automatic finish_test();
      $display("checks %0d mismatches %0d", comparisons, err_total);
      if (err_total == 0 && comparisons > 0) begin
         $display("ALL CHECKS OK");
      end else begin
         $display("CHECKS NOT OK");
      end
      $finish;
   endtask

   task automatic check(input string name, input logic [31:0] seen,
                        input logic [31:0] exp);
      comparisons++;
      if (seen !== exp) begin
         err_total++;
         $display("[FAIL] %s expected %h seen %h", name, exp, seen);
      end
   endtask

   task automatic step(input int n);
      repeat (n) @(posedge pclk);
   endtask

   // one transfer; setup then access held until pready is sampled
   task automatic apb(input logic w, input logic [11:0] a,
                      input logic [31:0] d);
      int n;
      n = 0;
      @(posedge pclk);
      psel <= 1'b1;
      penable <= 1'b0;
      pwrite <= w;
      paddr <= a;
      pwdata <= d;
      @(posedge pclk);
      penable <= 1'b1;
      do begin
         @(posedge pclk);
         n++;
      end while (pready !== 1'b1 && n < 20);
      rd = prdata;
      rerr = pslverr;
      psel <= 1'b0;
      penable <= 1'b0;
      if (n >= 20) begin
         check("pready", 32'h0, 32'h1);
         finish_test();
      end
   endtask

   task automatic chk_mode(input power_mode_pkg::mode_t m);
      apb(1'b0, power_mode_pkg::STATUS_ADDR, 32'h0);
      check("mode", {29'h0, rd[30:28]}, {29'h0, m});
   endtask

   // hold the button long enough for a wake, then let go
   task automatic press(input int n);
      want.pushbutton_n <= 1'b0;
      step(n);
      want.pushbutton_n <= 1'b1;
      step(16);
   endtask

   initial begin
      err_total = 0;
      comparisons = 0;
      presetn = 1'b0;
      psel = 1'b0;
      penable = 1'b0;
      pwrite = 1'b0;
      paddr = 12'h000;
      pwdata = 32'h0;
      pstrb = 4'hF;
      want = power_mode_pkg::SENSE_RESET;
      want.bat_above_uv = 1'b1;
      want.bat_above_uv_hyst = 1'b1;
      want.bat_above_uv_max = 1'b1;
      step(8);
      check("power", {16'h0, power},
            {16'h0, power_mode_pkg::POWER_OUT_RESET});
      presetn <= 1'b1;
      step(2);
      check("rail", {31'h0, power.internal_rail}, 32'h1);
      apb(1'b0, power_mode_pkg::CTRL_ADDR, 32'h0);
      check("ctrl", rd, 32'h0);
      apb(1'b0, 12'h010, 32'h0);
      check("unmapped", {31'h0, rerr}, 32'h1);
      step(16);
      chk_mode(power_mode_pkg::MODE_SHIP);
      check("bat_switch", {31'h0, power.battery_switch}, 32'h0);
      want.bat_above_uv_max <= 1'b0;
      press(WAKE + 10);
      chk_mode(power_mode_pkg::MODE_SHIP);
      want.bat_above_uv_max <= 1'b1;
      press(WAKE + 10);
      chk_mode(power_mode_pkg::MODE_ACTIVE);
      apb(1'b1, power_mode_pkg::CTRL_ADDR, 32'h2);
      want.low_power_pin_n <= 1'b0;
      step(12);
      chk_mode(power_mode_pkg::MODE_ACTIVE);
      step(8);
      chk_mode(power_mode_pkg::MODE_LOW_POWER);
      check("regulator", {31'h0, power.regulator}, 32'h1);
      check("clocks", {31'h0, power.clocks_run}, 32'h0);
      want.pushbutton_n <= 1'b0;
      step(16);
      chk_mode(power_mode_pkg::MODE_ACTIVE);
      check("clocks", {31'h0, power.clocks_run}, 32'h1);
      want.pushbutton_n <= 1'b1;
      step(16);
      chk_mode(power_mode_pkg::MODE_LOW_POWER);
      want.in_above_uv <= 1'b1;
      want.in_above_ov <= 1'b1;
      step(16);
      chk_mode(power_mode_pkg::MODE_ACTIVE);
      want.in_above_ov <= 1'b0;
      want.in_above_sleep_margin <= 1'b1;
      want.in_above_voltage_loop <= 1'b1;
      want.low_power_pin_n <= 1'b1;
      want.charge_enable_pin_n <= 1'b0;
      step(16);
      // ship request while the adapter is present must wait
      apb(1'b1, power_mode_pkg::CTRL_ADDR, 32'h7);
      step(4);
      chk_mode(power_mode_pkg::MODE_ADAPTER);
      check("rail_in", {31'h0, power.system_rail_from_input}, 32'h1);
      check("charging", {31'h0, power.charging}, 32'h1);
      want.in_above_uv <= 1'b0;
      want.in_above_sleep_margin <= 1'b0;
      want.in_above_voltage_loop <= 1'b0;
      step(16);
      chk_mode(power_mode_pkg::MODE_SHIP);
      press(WAKE + 10);
      want.pushbutton_n <= 1'b0;
      step(16);
      apb(1'b1, power_mode_pkg::CTRL_ADDR, 32'h1);
      step(16);
      chk_mode(power_mode_pkg::MODE_ACTIVE);
      want.pushbutton_n <= 1'b1;
      step(16);
      chk_mode(power_mode_pkg::MODE_SHIP);
      // hardware reset with the pin low; button held through power-up
      want.low_power_pin_n <= 1'b0;
      want.pushbutton_n <= 1'b0;
      presetn <= 1'b0;
      step(8);
      presetn <= 1'b1;
      step(WAKE + 20);
      chk_mode(power_mode_pkg::MODE_ACTIVE);
      want.pushbutton_n <= 1'b1;
      step(16);
      chk_mode(power_mode_pkg::MODE_LOW_POWER);
      finish_test();
   end
endmodule

bind charger_power_mode_controller power_mode_chk #(
   .WAKE_CYCLES(WAKE_CYCLES)) chk (.pclk(pclk), .presetn(presetn),
   .psel(psel), .penable(penable), .pwrite(pwrite), .paddr(paddr),
   .pwdata(pwdata), .pstrb(pstrb), .prdata(prdata), .pready(pready),
   .pslverr(pslverr), .sense(sense), .serial_busy(serial_busy),
   .irq_pending(irq_pending), .power(power));
`default_nettype wire
